// File: verilog/sdci_core.sv
`timescale 1ns/1ps
`default_nettype none
module sdci_core (
  input  wire logic                         i_clk,
  input  wire logic                         i_rst,
  input  wire logic                         i_cke,
  input  wire logic                         i_cs_n,
  input  wire logic                         i_ras_n,
  input  wire logic                         i_cas_n,
  input  wire logic                         i_we_n,
  input  wire logic                         i_bank_select_high,
  input  wire logic                         i_bank_select_low,
  input  wire logic [sdci_pkg::ROW_W-1:0]   i_addr,
  input  wire logic [sdci_pkg::LANES-1:0]   i_dqm,
  input  wire logic [sdci_pkg::DQ_W-1:0]    i_dq_in,
  output logic      [sdci_pkg::DQ_W-1:0]    o_dq_out,
  output logic      [sdci_pkg::LANES-1:0]   o_dq_oe_n,
  output logic      [sdci_pkg::BANKS-1:0]   o_bank_open,
  output logic      [sdci_pkg::BANKS-1:0]   o_bank_ready,
  output logic      [sdci_pkg::MODE_W-1:0]  o_mode_reg,
  output logic                              o_self_refresh,
  output logic      [sdci_pkg::ROW_W-1:0]   o_refresh_row,
  output logic                              o_wr_ready,
  output logic                              o_wr_lost
);

  typedef struct packed {
    logic [3:0]                                open;
    logic [3:0][sdci_pkg::ROW_W-1:0]           row;
    logic [3:0][1:0]                           pre_cnt;
    logic [sdci_pkg::MODE_W-1:0]               mode;
    logic                                      bact;
    logic                                      bwr;
    logic                                      bap;
    logic                                      bfull;
    logic [1:0]                                bbank;
    logic [sdci_pkg::COL_W-1:0]                bcol;
    logic [3:0]                                bleft;
    logic                                      apw_on;
    logic [1:0]                                apw;
    logic [1:0]                                apw_bank;
    logic                                      sref;
    logic [sdci_pkg::ROW_W-1:0]                rrow;
    logic [2:0]                                rv;
    logic [2:0][sdci_pkg::DQ_W-1:0]            rd;
    logic [1:0][sdci_pkg::LANES-1:0]           dqmp;
    logic [sdci_pkg::DQ_W-1:0]                 dq_o;
    logic [sdci_pkg::LANES-1:0]                oe_n;
    logic [3:0]                                rdy;
    logic                                      wr_lost;
  } sdci_core_st_t;

  sdci_core_st_t          q, d;
  sdci_pkg::sdci_req_t    req;
  sdci_pkg::sdci_wbeat_t  wbeat;
  sdci_pkg::sdci_wbeat_t  dbeat;
  logic [sdci_pkg::DQ_W-1:0] store [2**sdci_pkg::STORE_W];
  logic                   rd_beat;
  logic                   wr_beat;
  logic                   fifo_ready;
  logic                   fifo_valid;
  logic [1:0]             beat_bank;
  logic [sdci_pkg::COL_W-1:0] beat_col;
  logic                   end_ev;
  logic                   end_wr;
  logic                   end_ap;
  logic [1:0]             end_bank;

  function automatic logic [3:0] burst_len(input logic [2:0] bl);
    case (bl)
      3'h0:    return 4'h1;
      3'h1:    return 4'h2;
      3'h2:    return 4'h4;
      3'h3:    return sdci_pkg::BL_FIXED_MAX;
      default: return 4'h1;
    endcase
  endfunction : burst_len

  function automatic logic [1:0] cl_stage(input logic [2:0] cl);
    return (cl == 3'h3) ? 2'h2 : (cl == 3'h1) ? 2'h0 : 2'h1;
  endfunction : cl_stage

  sdci_decode u_decode (
    .i_cke              (i_cke),
    .i_cs_n             (i_cs_n),
    .i_ras_n            (i_ras_n),
    .i_cas_n            (i_cas_n),
    .i_we_n             (i_we_n),
    .i_bank_select_high (i_bank_select_high),
    .i_bank_select_low  (i_bank_select_low),
    .i_addr             (i_addr),
    .o_req              (req)
  );

  // Write beats queue here; the array port is shared with read beats
  sdci_fifo #(
    .W ($bits(sdci_pkg::sdci_wbeat_t)),
    .D (sdci_pkg::FIFO_DEPTH)
  ) u_wfifo (
    .i_clk   (i_clk),
    .i_rst   (i_rst),
    .i_valid (wr_beat),
    .o_ready (fifo_ready),
    .i_data  (wbeat),
    .o_valid (fifo_valid),
    .i_ready (!rd_beat),
    .o_data  (dbeat)
  );

  always_comb
  begin
    logic [3:0] len;
    logic [1:0] st;
    d         = q;
    len       = burst_len(q.mode[sdci_pkg::BL_LSB +: 3]);
    st        = cl_stage(q.mode[sdci_pkg::CL_LSB +: 3]);
    rd_beat   = 1'b0;
    wr_beat   = 1'b0;
    beat_bank = q.bbank;
    beat_col  = q.bcol;
    end_ev    = 1'b0;
    end_wr    = q.bwr;
    end_ap    = q.bap;
    end_bank  = q.bbank;
    for (int b = 0; b < 4; b++)
      if (q.pre_cnt[b] != 2'h0)
        d.pre_cnt[b] = q.pre_cnt[b] - 2'h1;
    if (q.apw_on)
    begin
      d.apw = q.apw - 2'h1;
      if (q.apw == 2'h1)
      begin
        d.apw_on                = 1'b0;
        d.open[q.apw_bank]      = 1'b0;
        d.pre_cnt[q.apw_bank]   = sdci_pkg::PRE_CYC;
      end
    end
    if (q.sref)
    begin
      if (i_cke)
        d.sref = 1'b0;
    end
    else
    begin
      case (req.cmd)
        sdci_pkg::CMD_ACT:
        begin
          d.open[req.bank] = 1'b1;
          d.row[req.bank]  = req.addr;
        end
        sdci_pkg::CMD_RD, sdci_pkg::CMD_WR:
        begin
          beat_bank = req.bank;
          beat_col  = req.addr[sdci_pkg::COL_W-1:0];
          rd_beat   = req.cmd == sdci_pkg::CMD_RD;
          wr_beat   = req.cmd == sdci_pkg::CMD_WR;
          d.bwr     = wr_beat;
          d.bap     = req.addr[sdci_pkg::PRECHARGE_SCOPE_BIT];
          d.bbank   = req.bank;
          d.bcol    = beat_col + 1'b1;
          d.bfull   = q.mode[sdci_pkg::BL_LSB +: 3] == sdci_pkg::BL_FULL;
          d.bleft   = len - 4'h1;
          d.bact    = d.bfull || len != 4'h1;
          end_ev    = !d.bact;
          end_wr    = wr_beat;
          end_ap    = d.bap;
          end_bank  = req.bank;
        end
        sdci_pkg::CMD_BT:
          d.bact = 1'b0;
        sdci_pkg::CMD_PRE:
        begin
          if (req.addr[sdci_pkg::PRECHARGE_SCOPE_BIT])
          begin
            d.open    = '0;
            d.pre_cnt = {4{sdci_pkg::PRE_CYC}};
          end
          else
          begin
            d.open[req.bank]    = 1'b0;
            d.pre_cnt[req.bank] = sdci_pkg::PRE_CYC;
          end
        end
        sdci_pkg::CMD_AREF:
          d.rrow = q.rrow + 1'b1;
        sdci_pkg::CMD_SREF:
        begin
          d.sref = 1'b1;
          d.bact = 1'b0;
          d.rrow = q.rrow + 1'b1;
        end
        sdci_pkg::CMD_MODE:
          d.mode = req.addr[sdci_pkg::MODE_W-1:0];
        default:
        begin
        end
      endcase
      // Running burst advances while enabled, even when deselected
      if (q.bact && i_cke && req.cmd != sdci_pkg::CMD_RD && req.cmd != sdci_pkg::CMD_WR
          && req.cmd != sdci_pkg::CMD_BT)
      begin
        rd_beat = !q.bwr;
        wr_beat = q.bwr;
        d.bcol  = q.bcol + 1'b1;
        if (!q.bfull)
        begin
          d.bleft = q.bleft - 4'h1;
          if (q.bleft == 4'h1)
          begin
            d.bact = 1'b0;
            end_ev = 1'b1;
          end
        end
      end
    end
    if (end_ev && end_ap)
    begin
      if (end_wr)
      begin
        d.apw_on   = 1'b1;
        d.apw      = sdci_pkg::WR_CYC;
        d.apw_bank = end_bank;
      end
      else
      begin
        d.open[end_bank]    = 1'b0;
        d.pre_cnt[end_bank] = sdci_pkg::PRE_CYC;
      end
    end
    d.wr_lost = wr_beat && !fifo_ready;
    d.dqmp    = {q.dqmp[0], i_dqm};
    d.rv      = {q.rv[1:0], rd_beat};
    d.rd      = {q.rd[1:0], store[{beat_bank, beat_col[sdci_pkg::STORE_IDX_W-1:0]}]};
    d.dq_o    = q.rd[st];
    for (int l = 0; l < sdci_pkg::LANES; l++)
      d.oe_n[l] = !(q.rv[st] && !q.dqmp[1][l]);
    for (int b = 0; b < 4; b++)
      d.rdy[b] = !d.open[b] && d.pre_cnt[b] == 2'h0;
  end

  always_comb
  begin
    wbeat.idx     = {beat_bank, beat_col[sdci_pkg::STORE_IDX_W-1:0]};
    wbeat.lane_en = ~i_dqm;
    wbeat.data    = i_dq_in;
  end

  always_ff @(posedge i_clk)
  begin
    if (i_rst)
      q <= '0;
    else
      q <= d;
  end

  genvar g;
  generate
    for (g = 0; g < sdci_pkg::LANES; g++)
    begin : g_lane
      always_ff @(posedge i_clk)
      begin
        if (fifo_valid && !rd_beat && dbeat.lane_en[g])
          store[dbeat.idx][g*sdci_pkg::LANE_W +: sdci_pkg::LANE_W] <=
            dbeat.data[g*sdci_pkg::LANE_W +: sdci_pkg::LANE_W];
      end
    end
  endgenerate

  assign o_dq_out       = q.dq_o;
  assign o_dq_oe_n      = q.oe_n;
  assign o_bank_open    = q.open;
  assign o_bank_ready   = q.rdy;
  assign o_mode_reg     = q.mode;
  assign o_self_refresh = q.sref;
  assign o_refresh_row  = q.rrow;
  assign o_wr_ready     = fifo_ready;
  assign o_wr_lost      = q.wr_lost;

  a_act_opens_row: assert property (@(posedge i_clk) disable iff (i_rst)
    (!q.sref && req.cmd == sdci_pkg::CMD_ACT)
      |=> (q.open[$past(req.bank)] && q.row[$past(req.bank)] == $past(req.addr)))
    else $error("activate did not open the addressed row");

  a_desel_holds: assert property (@(posedge i_clk) disable iff (i_rst)
    (i_cs_n && !q.sref) |=> ($stable(q.mode) && $stable(q.row) && (q.open & ~$past(q.open)) == 4'h0))
    else $error("deselect changed command state");

  a_mode_load: assert property (@(posedge i_clk) disable iff (i_rst)
    (!q.sref && req.cmd == sdci_pkg::CMD_MODE) |=> (o_mode_reg == $past(i_addr[11:0])))
    else $error("mode register not loaded from address");

  a_rd_mask_hiz: assert property (@(posedge i_clk) disable iff (i_rst)
    i_dqm[0] |-> ##3 o_dq_oe_n[0])
    else $error("masked read lane drove data");

  a_pre_all: assert property (@(posedge i_clk) disable iff (i_rst)
    (!q.sref && req.cmd == sdci_pkg::CMD_PRE && i_addr[10]) |=> (o_bank_open == 4'h0))
    else $error("precharge all left a bank open");

  a_bt_stops: assert property (@(posedge i_clk) disable iff (i_rst)
    (!q.sref && req.cmd == sdci_pkg::CMD_BT) |=> !q.bact)
    else $error("terminate did not stop the burst");

  a_sref_entry: assert property (@(posedge i_clk) disable iff (i_rst)
    (!q.sref && req.cmd == sdci_pkg::CMD_SREF) |=> (o_self_refresh && !q.bact))
    else $error("self refresh not entered");

  a_aref_counts: assert property (@(posedge i_clk) disable iff (i_rst)
    (!q.sref && req.cmd == sdci_pkg::CMD_AREF) |=> (o_refresh_row == $past(o_refresh_row) + 1'b1))
    else $error("refresh counter did not advance");

  a_ap_once: assert property (@(posedge i_clk) disable iff (i_rst)
    (!q.sref && req.cmd == sdci_pkg::CMD_RD && !i_addr[10]) |=> !q.bap)
    else $error("auto close persisted from earlier access");

  a_wmask_lane: assert property (@(posedge i_clk) disable iff (i_rst)
    wr_beat |-> (wbeat.lane_en == ~i_dqm))
    else $error("write mask not applied in the data cycle");

endmodule : sdci_core
`default_nettype wire

// File: inc/sdci_pkg.sv
package sdci_pkg;

  // Array geometry, sixteen-bit data width
  localparam int unsigned BANKS       = 4;
  localparam int unsigned ROWS        = 8192;
  localparam int unsigned COLS_X4     = 2048;
  localparam int unsigned COLS_X8     = 1024;
  localparam int unsigned COLS_X16    = 512;
  localparam int unsigned ROW_W       = 13;
  localparam int unsigned COL_W       = 9;
  localparam int unsigned DQ_W        = 16;
  localparam int unsigned LANES       = 2;
  localparam int unsigned LANE_W      = 8;
  localparam int unsigned MODE_W      = 12;

  // Address bit positions
  localparam int unsigned PRECHARGE_SCOPE_BIT = 10;

  // Mode register fields
  localparam int unsigned BL_LSB      = 0;
  localparam int unsigned CL_LSB      = 4;
  localparam logic [2:0]  BL_FULL     = 3'h7;
  localparam logic [3:0]  BL_FIXED_MAX = 4'h8;

  // Local store keeps the low column bits of each bank
  localparam int unsigned STORE_IDX_W = 4;
  localparam int unsigned STORE_W     = 2 + STORE_IDX_W;

  localparam int unsigned FIFO_DEPTH  = 8;

  // Timing
  localparam int unsigned CLK_PERIOD_PS    = 40000;
  localparam int unsigned PRECHARGE_PERIOD_PS = 20000;
  localparam int unsigned WR_EXTRA_PS      = 7500;
  localparam int unsigned PRE_CYC_I =
    (PRECHARGE_PERIOD_PS + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
  localparam logic [1:0]  PRE_CYC = PRE_CYC_I < 1 ? 2'h1 : PRE_CYC_I[1:0];
  localparam int unsigned WR_CYC_I = 1 + (WR_EXTRA_PS + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
  localparam logic [1:0]  WR_CYC  = WR_CYC_I[1:0];

  typedef enum logic [3:0] {
    CMD_DESEL, CMD_NOP, CMD_ACT, CMD_RD, CMD_WR, CMD_BT,
    CMD_PRE, CMD_AREF, CMD_SREF, CMD_MODE
  } sdci_cmd_t;

  typedef struct packed {
    sdci_cmd_t        cmd;
    logic [1:0]       bank;
    logic [ROW_W-1:0] addr;
  } sdci_req_t;

  typedef struct packed {
    logic [STORE_W-1:0] idx;
    logic [LANES-1:0]   lane_en;
    logic [DQ_W-1:0]    data;
  } sdci_wbeat_t;

  function automatic sdci_cmd_t decode_cmd(input logic cs_n, input logic ras_n,
                                           input logic cas_n, input logic we_n,
                                           input logic cke);
    logic [2:0] s;
    s = {ras_n, cas_n, we_n};
    if (cs_n)
      return CMD_DESEL;
    if (!cke)
      return (s == 3'h1) ? CMD_SREF : CMD_NOP;
    case (s)
      3'h7:    return CMD_NOP;
      3'h6:    return CMD_BT;
      3'h3:    return CMD_ACT;
      3'h5:    return CMD_RD;
      3'h4:    return CMD_WR;
      3'h2:    return CMD_PRE;
      3'h1:    return CMD_AREF;
      default: return CMD_MODE;
    endcase
  endfunction : decode_cmd

endpackage : sdci_pkg

// File: verilog/sdci_decode.sv
`timescale 1ns/1ps
`default_nettype none
module sdci_decode (
  input  wire logic                       i_cke,
  input  wire logic                       i_cs_n,
  input  wire logic                       i_ras_n,
  input  wire logic                       i_cas_n,
  input  wire logic                       i_we_n,
  input  wire logic                       i_bank_select_high,
  input  wire logic                       i_bank_select_low,
  input  wire logic [sdci_pkg::ROW_W-1:0] i_addr,
  output var  sdci_pkg::sdci_req_t        o_req
);

  always_comb
  begin
    o_req.cmd  = sdci_pkg::decode_cmd(i_cs_n, i_ras_n, i_cas_n, i_we_n, i_cke);
    o_req.bank = {i_bank_select_high, i_bank_select_low};
    o_req.addr = i_addr;
  end

endmodule : sdci_decode
`default_nettype wire

// File: verilog/sdci_fifo.sv
`timescale 1ns/1ps
`default_nettype none
module sdci_fifo #(
  parameter int unsigned W = 24,
  parameter int unsigned D = 8
) (
  input  wire logic         i_clk,
  input  wire logic         i_rst,
  input  wire logic         i_valid,
  output logic              o_ready,
  input  wire logic [W-1:0] i_data,
  output logic              o_valid,
  input  wire logic         i_ready,
  output logic [W-1:0]      o_data
);

  localparam int unsigned PW = $clog2(D);

  typedef struct packed {
    logic [PW-1:0] wp;
    logic [PW-1:0] rp;
    logic [PW:0]   cnt;
    logic          full;
  } sdci_fifo_st_t;

  sdci_fifo_st_t q, d;
  logic [W-1:0]  mem [D];
  logic          push;
  logic          pop;

  assign push    = i_valid && !q.full;
  assign pop     = o_valid && i_ready;
  assign o_ready = !q.full;
  assign o_valid = q.cnt != '0;
  assign o_data  = mem[q.rp];

  always_comb
  begin
    d = q;
    if (push)
      d.wp = (q.wp == PW'(D - 1)) ? '0 : q.wp + 1'b1;
    if (pop)
      d.rp = (q.rp == PW'(D - 1)) ? '0 : q.rp + 1'b1;
    d.cnt  = q.cnt + (PW+1)'(push) - (PW+1)'(pop);
    d.full = d.cnt == (PW+1)'(D);
  end

  always_ff @(posedge i_clk)
  begin
    if (i_rst)
      q <= '0;
    else
      q <= d;
    if (push)
      mem[q.wp] <= i_data;
  end

  a_fifo_count: assert property (@(posedge i_clk) disable iff (i_rst)
    (push && !pop) |=> (q.cnt == $past(q.cnt) + 1'b1))
    else $error("fifo count did not follow a push");

  a_fifo_full: assert property (@(posedge i_clk) disable iff (i_rst)
    q.full |-> (!o_ready && q.cnt == (PW+1)'(D)))
    else $error("fifo full flag disagrees with count");

endmodule : sdci_fifo
`default_nettype wire

// File: sim/sdci_ctrl_model.sv
`timescale 1ns/1ps
`default_nettype none
module sdci_ctrl_model (
  input  wire logic   i_clk,
  output logic        o_cke,
  output logic        o_cs_n,
  output logic [2:0]  o_stb_n,
  output logic [1:0]  o_bank,
  output logic [12:0] o_addr,
  output logic [1:0]  o_dqm,
  output logic [15:0] o_dq
);
  initial
  begin
    o_cke = 1'b1;
    o_cs_n = 1'b0;
    o_stb_n = 3'h7;
    o_bank = 2'h0;
    o_addr = 13'h0000;
    o_dqm = 2'h0;
    o_dq = 16'h0000;
  end

  // Released data bus shows the inverse of its last value
  task automatic idle(input logic [1:0] m, input logic [15:0] d, input logic wr);
    @(posedge i_clk);
    o_cke <= 1'b1;
    o_cs_n <= 1'b0;
    o_stb_n <= 3'h7;
    o_dqm <= m;
    o_dq <= wr ? d : ~o_dq;
  endtask : idle

  task automatic nops(input int n);
    repeat (n) idle(2'h0, 16'h0000, 1'b0);
  endtask : nops

  task automatic send(input sdci_pkg::sdci_cmd_t c, input logic [1:0] b, input logic [12:0] a,
                      input logic [1:0] m, input logic [15:0] d, input logic k);
    @(posedge i_clk);
    o_cke <= k;
    o_cs_n <= (c == sdci_pkg::CMD_DESEL);
    o_bank <= b;
    o_addr <= a;
    o_dqm <= m;
    o_dq <= (c == sdci_pkg::CMD_WR) ? d : ~o_dq;
    // Deselect carries the activate pattern on purpose
    case (c)
      sdci_pkg::CMD_ACT, sdci_pkg::CMD_DESEL: o_stb_n <= 3'h3;
      sdci_pkg::CMD_RD: o_stb_n <= 3'h5;
      sdci_pkg::CMD_WR: o_stb_n <= 3'h4;
      sdci_pkg::CMD_BT: o_stb_n <= 3'h6;
      sdci_pkg::CMD_PRE: o_stb_n <= 3'h2;
      sdci_pkg::CMD_MODE: o_stb_n <= 3'h0;
      sdci_pkg::CMD_AREF, sdci_pkg::CMD_SREF: o_stb_n <= 3'h1;
      default: o_stb_n <= 3'h7;
    endcase
    if (c == sdci_pkg::CMD_MODE)
      nops(2);
    if (c == sdci_pkg::CMD_PRE || c == sdci_pkg::CMD_AREF)
      nops(2);
  endtask : send

  // Exit: enable goes high with no-ops only until recovery ends
  task automatic wake;
    nops(3);
  endtask : wake
endmodule : sdci_ctrl_model
`default_nettype wire

// File: sim/test_sdram_command_interface.sv
`timescale 1ns/1ps
`default_nettype none
module test_sdram_command_interface;
  logic        clk = 1'b0;
  logic        rst = 1'b1;
  logic        cke, cs_n, self_refresh, wr_ready, wr_lost;
  logic [2:0]  stb_n;
  logic [1:0]  bank, dqm, oe_n;
  logic [12:0] addr, refresh_row;
  logic [15:0] dq_in, dq_out;
  logic [3:0]  bank_open, bank_ready;
  logic [11:0] mode_reg;
  int          err_total = 0, checks = 0, cycles = 0;

  always #20 clk = ~clk;

  sdci_ctrl_model u_ctrl (.i_clk(clk), .o_cke(cke), .o_cs_n(cs_n), .o_stb_n(stb_n), .o_bank(bank),
    .o_addr(addr), .o_dqm(dqm), .o_dq(dq_in));

  sdci_core u_dut (.i_clk(clk), .i_rst(rst), .i_cke(cke), .i_cs_n(cs_n), .i_ras_n(stb_n[2]),
    .i_cas_n(stb_n[1]), .i_we_n(stb_n[0]), .i_bank_select_high(bank[1]), .i_bank_select_low(bank[0]),
    .i_addr(addr), .i_dqm(dqm), .i_dq_in(dq_in), .o_dq_out(dq_out), .o_dq_oe_n(oe_n),
    .o_bank_open(bank_open), .o_bank_ready(bank_ready), .o_mode_reg(mode_reg),
    .o_self_refresh(self_refresh), .o_refresh_row(refresh_row), .o_wr_ready(wr_ready), .o_wr_lost(wr_lost));

  task automatic results;
    $display("Checks %0d, errors %0d", checks, err_total);
    if (err_total == 0 && checks > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask : results

  task automatic chk(input logic [15:0] got, input logic [15:0] exp, input string what);
    checks++;
    if (got !== exp)
    begin
      err_total++;
      $display("Error at %0t: %s got %h, expected %h", $time, what, got, exp);
    end
  endtask : chk

  task automatic cmd(input sdci_pkg::sdci_cmd_t c, input logic [1:0] b, input logic [12:0] a);
    u_ctrl.send(c, b, a, 2'h0, 16'h0000, 1'b1);
  endtask : cmd

  task automatic step(input int n);
    u_ctrl.nops(n);
    #1;
  endtask : step

  always @(posedge clk)
  begin
    cycles <= cycles + 1;
    if (cycles == 5000)
    begin
      err_total = err_total + 1;
      $display("Error at %0t: timeout", $time);
      results();
    end
  end

  initial
  begin
    repeat (12) @(posedge clk);
    rst <= 1'b0;
    step(2);
    chk(16'(bank_open), 16'h0000, "open at reset");
    chk(16'(refresh_row), 16'h0000, "row at reset");
    // Banks idle; bit 12 must not reach the mode register
    u_ctrl.send(sdci_pkg::CMD_MODE, 2'h3, 13'h1021, 2'h0, 16'h0000, 1'b1);
    step(1);
    chk(16'(mode_reg), 16'h0021, "mode");
    cmd(sdci_pkg::CMD_ACT, 2'h1, 13'h1abc);
    cmd(sdci_pkg::CMD_ACT, 2'h2, 13'h0123);
    step(1);
    chk(16'(bank_open), 16'h0006, "two open");
    chk(16'(bank_ready[2:1]), 16'h0000, "not idle");
    u_ctrl.send(sdci_pkg::CMD_WR, 2'h1, 13'h0004, 2'h0, 16'h1111, 1'b1);
    u_ctrl.idle(2'h0, 16'h2222, 1'b1);
    u_ctrl.send(sdci_pkg::CMD_WR, 2'h1, 13'h0004, 2'h2, 16'habcd, 1'b1);
    u_ctrl.idle(2'h3, 16'h5555, 1'b1);
    step(4);
    chk(16'({wr_ready, wr_lost}), 16'h0002, "queue flags");
    cmd(sdci_pkg::CMD_RD, 2'h1, 13'h1a04);
    u_ctrl.idle(2'h1, 16'h0000, 1'b0);
    step(2);
    chk(dq_out, 16'h11cd, "merge");
    chk(16'(oe_n), 16'h0000, "lanes on");
    step(1);
    chk(16'(dq_out[15:8]), 16'h0022, "kept");
    chk(16'(oe_n), 16'h0001, "lane off");
    chk(16'(bank_open), 16'h0006, "still open");
    cmd(sdci_pkg::CMD_PRE, 2'h1, 13'h1bff);
    step(2);
    chk(16'(bank_open), 16'h0004, "one closed");
    chk(16'(bank_ready[1]), 16'h0001, "idle again");
    cmd(sdci_pkg::CMD_PRE, 2'h1, 13'h0400);
    step(1);
    chk(16'(bank_open), 16'h0000, "all closed");
    cmd(sdci_pkg::CMD_ACT, 2'h0, 13'h0005);
    cmd(sdci_pkg::CMD_RD, 2'h0, 13'h0404);
    step(6);
    chk(16'(bank_open[0]), 16'h0000, "read close");
    cmd(sdci_pkg::CMD_ACT, 2'h0, 13'h0005);
    cmd(sdci_pkg::CMD_RD, 2'h0, 13'h0004);
    step(6);
    chk(16'(bank_open[0]), 16'h0001, "no carry");
    u_ctrl.send(sdci_pkg::CMD_WR, 2'h0, 13'h0404, 2'h0, 16'h7777, 1'b1);
    u_ctrl.idle(2'h0, 16'h8888, 1'b1);
    step(6);
    chk(16'(bank_open[0]), 16'h0000, "write close");
    // Full page burst, deselect inside it, then cut short
    u_ctrl.send(sdci_pkg::CMD_MODE, 2'h0, 13'h0027, 2'h0, 16'h0000, 1'b1);
    cmd(sdci_pkg::CMD_ACT, 2'h3, 13'h0010);
    cmd(sdci_pkg::CMD_RD, 2'h3, 13'h0000);
    cmd(sdci_pkg::CMD_DESEL, 2'h0, 13'h0000);
    cmd(sdci_pkg::CMD_BT, 2'h3, 13'h0000);
    step(2);
    chk(16'(oe_n), 16'h0000, "burst runs");
    step(1);
    chk(16'(oe_n), 16'h0003, "burst cut");
    chk(16'(bank_open), 16'h0008, "deselect");
    cmd(sdci_pkg::CMD_PRE, 2'h0, 13'h0400);
    u_ctrl.send(sdci_pkg::CMD_ACT, 2'h0, 13'h0001, 2'h0, 16'h0000, 1'b0);
    step(1);
    chk(16'(bank_open), 16'h0000, "enable low");
    cmd(sdci_pkg::CMD_AREF, 2'h3, 13'h1fff);
    step(1);
    chk(16'(refresh_row), 16'h0001, "refresh");
    chk(16'(bank_open), 16'h0000, "refresh addr");
    u_ctrl.send(sdci_pkg::CMD_SREF, 2'h0, 13'h0000, 2'h0, 16'h0000, 1'b0);
    u_ctrl.send(sdci_pkg::CMD_ACT, 2'h1, 13'h0002, 2'h0, 16'h0000, 1'b0);
    #1;
    chk(16'({self_refresh, refresh_row}), 16'h2002, "self refresh");
    u_ctrl.wake();
    #1;
    chk(16'({self_refresh, bank_open}), 16'h0000, "wake");
    // Full page write through the queue, then read back in order
    cmd(sdci_pkg::CMD_ACT, 2'h0, 13'h0005);
    u_ctrl.send(sdci_pkg::CMD_WR, 2'h0, 13'h0000, 2'h0, 16'h00a0, 1'b1);
    for (int i = 1; i < 9; i++)
    begin
      u_ctrl.idle(2'h0, 16'h00a0 + 16'(i), 1'b1);
      #1;
      chk(16'(wr_ready), 16'h0001, "room");
    end
    cmd(sdci_pkg::CMD_BT, 2'h0, 13'h0000);
    #1;
    chk(16'(wr_ready), 16'h0001, "room");
    chk(16'(wr_lost), 16'h0000, "lost");
    cmd(sdci_pkg::CMD_RD, 2'h0, 13'h0000);
    step(3);
    for (int i = 0; i < 8; i++)
    begin
      chk(dq_out, 16'h00a0 + 16'(i), "order");
      step(1);
    end
    cmd(sdci_pkg::CMD_BT, 2'h0, 13'h0000);
    step(3);
    chk(16'(oe_n), 16'h0003, "empty");
    results();
  end
endmodule : test_sdram_command_interface
`default_nettype wire
